/* File: src/serializer_base_control_pkg.sv */
// Purpose: Constants shared by the serializer base control register bank.
// Assumes: Registers are reached over the serial control bus pins only.
// Notes:   Offsets are byte addresses on the serial control bus.
package serializer_base_control_pkg;

  // ===========================================================================
  // Register offsets
  localparam logic [7:0] OFS_BUS_ADDRESS_SELECT = 8'h00;
  localparam logic [7:0] OFS_RESET_AND_POWER_CONTROL = 8'h01;
  localparam logic [7:0] OFS_LINK_AND_INPUT_CONFIG = 8'h03;

  // ===========================================================================
  // Reset values
  localparam logic [7:0] RST_BUS_ADDRESS_SELECT = 8'h00;
  localparam logic [7:0] RST_RESET_AND_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_LINK_AND_INPUT_CONFIG = 8'hd2;

  // ===========================================================================
  // Field positions
  localparam int ADDR_OVERRIDE_BIT = 0;
  localparam int AUTO_POWER_DOWN_BIT = 7;
  localparam int FULL_DIGITAL_RESET_BIT = 1;
  localparam int LOGIC_ONLY_RESET_BIT = 0;
  localparam int CRC_CHECKER_EN_BIT = 7;
  localparam int INPUT_FILTER_EN_BIT = 4;
  localparam int PASSTHROUGH_EN_BIT = 3;
  localparam int OSC_AUTO_SWITCH_BIT = 1;
  localparam int PIXEL_STROBE_EDGE_BIT = 0;
  // Writable bits of the configuration register; the rest read as zero once the register is written.
  localparam logic [7:0] CFG_WRITE_MASK = 8'h9b;

  // ===========================================================================
  // Pin-selected bus addresses: base plus twice the select code.
  localparam logic [6:0] PIN_ADDR_BASE = 7'h0c;
  localparam logic [3:0] BYTE_BITS = 4'h8;

endpackage

/* File: src/serializer_base_control_regs.sv */
// Purpose: Serial control bus slave with the base control and configuration registers.
// Assumes: scl_in and sda_in are synchronous to clk_sys and much slower than it.
// Notes:   sda_out is always low; sda_oe_n low pulls the line down.
// Summary of operation
// - Address register bits 7:1 hold the seven-bit bus address of the device.
// - Address register bit 0 set selects register address, else the pin address.
// - Reset register bit 7 set powers down while no control channel link exists.
// - Writing 1 to reset bit 1 resets logic and registers but not the bus engine; self-clearing.
// - Writing 1 to reset bit 0 resets logic but keeps registers; self-clearing.
// - Configuration bit 7 enables the back-channel CRC checker.
// - Configuration bit 4 enables rejecting control pulses under two pixel clocks.
// - Configuration bit 3 enables bus pass-through mode.
// - Configuration bit 1 enables switch to internal oscillator without pixel clock.
// - Configuration bit 0 picks rising (1) or falling (0) pixel strobe edge.
// - Device acknowledges its address and every written data byte by pulling data low.
// - The address select pin chooses one of sixteen bus addresses.
`timescale 1ns/1ps
module serializer_base_control_regs (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Serial control bus.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Device status inputs.
  input wire logic [3:0] address_select_pin,
  input wire logic link_detected,
  input wire logic pclk_present,
  // Control outputs.
  output logic [6:0] active_bus_addr,
  output logic power_down,
  output logic logic_reset,
  output logic crc_checker_en,
  output logic input_filter_en,
  output logic passthrough_en,
  output logic osc_auto_switch_en,
  output logic osc_select,
  output logic pixel_strobe_edge_select
);

  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} bus_state_t;
  function automatic logic [6:0] pin_to_addr(input logic [3:0] code);
    pin_to_addr = serializer_base_control_pkg::PIN_ADDR_BASE + {2'b00, code, 1'b0};
  endfunction

  // ===========================================================================
  // Register file state
  logic [7:0] addr_reg_r, addr_reg_nxt, cfg_r, cfg_nxt;
  logic apd_r, apd_nxt, full_rst_r, full_rst_nxt, logic_rst_r, logic_rst_nxt;
  // Write strobe from the bus engine.
  logic wr_en;
  logic [7:0] wr_addr, wr_data;

  // ===========================================================================
  // Bus engine state
  bus_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, rd_byte;
  logic [1:0] phase_r, phase_nxt;
  logic rw_r, rw_nxt, nack_r, nack_nxt, drive_r, drive_nxt;
  logic scl_q_r, sda_q_r, scl_rise, scl_fall, start_cond, stop_cond;

  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] idr,
                                          input logic pd, input logic [7:0] cf);
    case (a)
      serializer_base_control_pkg::OFS_BUS_ADDRESS_SELECT: read_reg = idr;
      serializer_base_control_pkg::OFS_RESET_AND_POWER_CONTROL: read_reg = {pd, 7'h00};
      serializer_base_control_pkg::OFS_LINK_AND_INPUT_CONFIG: read_reg = cf;
      default: read_reg = 8'h00;
    endcase
  endfunction
  assign active_bus_addr = addr_reg_r[serializer_base_control_pkg::ADDR_OVERRIDE_BIT] ?
                           addr_reg_r[7:1] : pin_to_addr(address_select_pin);
  assign power_down = apd_r & ~link_detected;
  assign logic_reset = logic_rst_r | full_rst_r;
  assign crc_checker_en = cfg_r[serializer_base_control_pkg::CRC_CHECKER_EN_BIT];
  assign input_filter_en = cfg_r[serializer_base_control_pkg::INPUT_FILTER_EN_BIT];
  assign passthrough_en = cfg_r[serializer_base_control_pkg::PASSTHROUGH_EN_BIT];
  assign osc_auto_switch_en = cfg_r[serializer_base_control_pkg::OSC_AUTO_SWITCH_BIT];
  assign osc_select = osc_auto_switch_en & ~pclk_present;
  assign pixel_strobe_edge_select =
    cfg_r[serializer_base_control_pkg::PIXEL_STROBE_EDGE_BIT];
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_r;

  // ===========================================================================
  // Bus engine
  assign scl_rise = scl_in & ~scl_q_r;
  assign scl_fall = ~scl_in & scl_q_r;
  assign start_cond = scl_in & scl_q_r & sda_q_r & ~sda_in;
  assign stop_cond = scl_in & scl_q_r & ~sda_q_r & sda_in;
  assign rd_byte = read_reg(ptr_r, addr_reg_r, apd_r, cfg_r);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    phase_nxt = phase_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    drive_nxt = drive_r;
    wr_en = 1'b0;
    wr_addr = ptr_r;
    wr_data = sh_r;
    if (start_cond) begin
      state_nxt = ST_RX;
      cnt_nxt = 4'h0;
      phase_nxt = 2'd0;
      drive_nxt = 1'b0;
    end else if (stop_cond) begin
      state_nxt = ST_IDLE;
      drive_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_RX: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_in};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == serializer_base_control_pkg::BYTE_BITS) begin
            state_nxt = ST_ACK;
            drive_nxt = 1'b1;
            if (phase_r == 2'd0) begin
              rw_nxt = sh_r[0];
              phase_nxt = 2'd1;
              if (sh_r[7:1] != active_bus_addr) begin
                state_nxt = ST_IDLE;
                drive_nxt = 1'b0;
              end
            end else if (phase_r == 2'd1) begin
              ptr_nxt = sh_r;
              phase_nxt = 2'd2;
            end else begin
              wr_en = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (rw_r && phase_r == 2'd1) begin
              state_nxt = ST_TX;
              sh_nxt = {rd_byte[6:0], 1'b0};
              drive_nxt = ~rd_byte[7];
              cnt_nxt = 4'h1;
              ptr_nxt = ptr_r + 8'h01;
            end else begin
              state_nxt = ST_RX;
              drive_nxt = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == serializer_base_control_pkg::BYTE_BITS) begin
              state_nxt = ST_TXACK;
              drive_nxt = 1'b0;
            end else begin
              drive_nxt = ~sh_r[7];
              sh_nxt = {sh_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            nack_nxt = sda_in;
          end else if (scl_fall) begin
            if (nack_r) begin
              state_nxt = ST_IDLE;
            end else begin
              state_nxt = ST_TX;
              sh_nxt = {rd_byte[6:0], 1'b0};
              drive_nxt = ~rd_byte[7];
              cnt_nxt = 4'h1;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        ST_IDLE: drive_nxt = 1'b0;
        default: begin
          state_nxt = ST_IDLE;
          drive_nxt = 1'b0;
        end
      endcase
    end
  end

  // The bus engine survives a full digital reset so the acknowledge completes.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      phase_r <= 2'd0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      drive_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      phase_r <= phase_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      drive_r <= drive_nxt;
    end
  end

  // ===========================================================================
  // Register file
  always_comb begin
    addr_reg_nxt = addr_reg_r;
    apd_nxt = apd_r;
    cfg_nxt = cfg_r;
    full_rst_nxt = 1'b0;
    logic_rst_nxt = 1'b0;
    if (full_rst_r) begin
      addr_reg_nxt = serializer_base_control_pkg::RST_BUS_ADDRESS_SELECT;
      apd_nxt = serializer_base_control_pkg::RST_RESET_AND_POWER_CONTROL[7];
      cfg_nxt = serializer_base_control_pkg::RST_LINK_AND_INPUT_CONFIG;
    end else if (wr_en) begin
      case (wr_addr)
        serializer_base_control_pkg::OFS_BUS_ADDRESS_SELECT: addr_reg_nxt = wr_data;
        serializer_base_control_pkg::OFS_RESET_AND_POWER_CONTROL: begin
          apd_nxt = wr_data[serializer_base_control_pkg::AUTO_POWER_DOWN_BIT];
          full_rst_nxt = wr_data[serializer_base_control_pkg::FULL_DIGITAL_RESET_BIT];
          logic_rst_nxt = wr_data[serializer_base_control_pkg::LOGIC_ONLY_RESET_BIT];
        end
        serializer_base_control_pkg::OFS_LINK_AND_INPUT_CONFIG: begin
          cfg_nxt = wr_data & serializer_base_control_pkg::CFG_WRITE_MASK;
        end
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_reg_r <= serializer_base_control_pkg::RST_BUS_ADDRESS_SELECT;
      apd_r <= 1'b0;
      cfg_r <= serializer_base_control_pkg::RST_LINK_AND_INPUT_CONFIG;
      full_rst_r <= 1'b0;
      logic_rst_r <= 1'b0;
    end else if (clk_en) begin
      addr_reg_r <= addr_reg_nxt;
      apd_r <= apd_nxt;
      cfg_r <= cfg_nxt;
      full_rst_r <= full_rst_nxt;
      logic_rst_r <= logic_rst_nxt;
    end
  end

  // ===========================================================================
  // Assertions
  AST_ADDR_SEL: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !addr_reg_r[0] |-> active_bus_addr == pin_to_addr(address_select_pin))
    else $error("Pin address not used without override.");
  AST_ADDR_OVR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_en && clk_en && wr_addr == 8'h00 && wr_data[0] |=> active_bus_addr == $past(wr_data[7:1]))
    else $error("Register address override not applied.");
  AST_PWRDN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    apd_r && !link_detected |-> power_down)
    else $error("No power down without link.");
  AST_FULL_RST: assert property (@(posedge clk_sys) disable iff (sys_rst)
    full_rst_r && clk_en |=> cfg_r == 8'hd2 && addr_reg_r == 8'h00 && !full_rst_r)
    else $error("Full digital reset did not restore registers.");
  AST_LOGIC_RST: assert property (@(posedge clk_sys) disable iff (sys_rst)
    logic_rst_r && !full_rst_r && clk_en |=> $stable(cfg_r) && !logic_rst_r)
    else $error("Logic reset disturbed registers or stuck.");
  AST_CFG_WR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_en && clk_en && wr_addr == 8'h03 && !full_rst_r
    |=> crc_checker_en == $past(wr_data[7]) && input_filter_en == $past(wr_data[4]))
    else $error("Configuration write not applied.");
  AST_OSC: assert property (@(posedge clk_sys) disable iff (sys_rst)
    osc_select |-> osc_auto_switch_en && !pclk_present)
    else $error("Oscillator switch without cause.");
  AST_ACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_r == ST_ACK |-> !sda_oe_n)
    else $error("Acknowledge not driven low.");
  AST_RST_DEF: assert property (@(posedge clk_sys)
    sys_rst |=> cfg_r == 8'hd2 && !apd_r && !power_down)
    else $error("Reset defaults wrong.");
endmodule // serializer_base_control_regs

/* File: sim/i2c_host_model.sv */
// Purpose: Behavioural host controller for the serial control bus.
// Assumes: Called only from the bench's main sequence, one transfer at a time.
// Notes:   The host releases SDA by driving 1; the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
module i2c_host_model (
  // Clock.
  input wire logic clk_sys,
  // Bus lines.
  output logic scl,
  output logic sda_drv,
  input wire logic sda_in
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // ==========================================================================
  // Bus phases
  // Each phase lasts four system clocks, above the three-cycle minimum.
  task automatic hp();
    repeat (4) @(negedge clk_sys);
  endtask
  // Start or repeated start: release SDA, raise SCL, then pull SDA low.
  task automatic start();
    sda_drv = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_drv = 1'b0;
    hp();
    scl = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_drv = 1'b1;
    hp();
  endtask
  // Sends d MSB first and samples the line; last is the host's own ninth bit.
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = {d, last};
    for (int i = 8; i >= 0; i--) begin
      sda_drv = tx[i];
      hp();
      scl = 1'b1;
      hp();
      rx[i] = sda_in;
      scl = 1'b0;
      hp();
    end
    q = rx[8:1];
    ack = ~rx[0];
  endtask
endmodule // i2c_host_model

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the serializer base control register bank.
// Assumes: The bus wire has a pull-up; the host model stands on the far side.
// Notes:   Pin code 3 gives the default bus address 0x12.
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] ofs; logic [7:0] wd; logic [7:0] rd;} row_t;
  logic clk_sys, sys_rst, clk_en, scl, host_sda, link_detected, pclk_present;
  logic sda_out, sda_oe_n, power_down, logic_reset, crc_checker_en, input_filter_en;
  logic passthrough_en, osc_auto_switch_en, osc_select, pixel_strobe_edge_select;
  logic [3:0] address_select_pin;
  logic [6:0] active_bus_addr, dev;
  logic [7:0] d, q, cfg_pins;
  logic ack;
  int failures = 0, n_compared = 0, pulses = 0, p0;
  row_t rows [6] = '{'{8'h03, 8'hff, 8'h9b}, '{8'h03, 8'h00, 8'h00}, '{8'h03, 8'h19, 8'h19},
                     '{8'h02, 8'h55, 8'h00}, '{8'h01, 8'h80, 8'h80}, '{8'h01, 8'h00, 8'h00}};
  wire sda_w = host_sda & (sda_oe_n | sda_out);
  assign cfg_pins = {crc_checker_en, 2'b00, input_filter_en, passthrough_en, 1'b0,
                     osc_auto_switch_en, pixel_strobe_edge_select};
  i2c_host_model i_i2c_host_model (.clk_sys(clk_sys), .scl(scl), .sda_drv(host_sda),
                                   .sda_in(sda_w));
  serializer_base_control_regs i_serializer_base_control_regs (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_pin(address_select_pin),
    .link_detected(link_detected), .pclk_present(pclk_present),
    .active_bus_addr(active_bus_addr), .power_down(power_down), .logic_reset(logic_reset),
    .crc_checker_en(crc_checker_en), .input_filter_en(input_filter_en),
    .passthrough_en(passthrough_en), .osc_auto_switch_en(osc_auto_switch_en),
    .osc_select(osc_select), .pixel_strobe_edge_select(pixel_strobe_edge_select));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (logic_reset === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  // ==========================================================================
  // Checking and bus tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] wd, input logic exp);
    i_i2c_host_model.start();
    i_i2c_host_model.xfer({dev, 1'b0}, 1'b1, q, ack);
    check("address ack", {7'h00, ack}, {7'h00, exp});
    if (exp) begin
      i_i2c_host_model.xfer(ofs, 1'b1, q, ack);
      check("pointer ack", {7'h00, ack}, 8'h01);
      i_i2c_host_model.xfer(wd, 1'b1, q, ack);
      check("data ack", {7'h00, ack}, 8'h01);
    end
    i_i2c_host_model.stop();
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] rdata);
    i_i2c_host_model.start();
    i_i2c_host_model.xfer({dev, 1'b0}, 1'b1, q, ack);
    i_i2c_host_model.xfer(ofs, 1'b1, q, ack);
    i_i2c_host_model.start();
    i_i2c_host_model.xfer({dev, 1'b1}, 1'b1, q, ack);
    i_i2c_host_model.xfer(8'hff, 1'b1, rdata, ack);
    i_i2c_host_model.stop();
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    address_select_pin = 4'h3;
    link_detected = 1'b0;
    pclk_present = 1'b1;
    dev = 7'h12;
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    rd(8'h03, d);
    check("config reset", d, 8'hd2);
    check("config pins reset", cfg_pins, 8'h92);
    rd(8'h01, d);
    check("reset reg reset", d, 8'h00);
    check("power down off", {7'h00, power_down}, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].ofs, rows[i].wd, 1'b1);
      rd(rows[i].ofs, d);
      check("readback", d, rows[i].rd);
      if (rows[i].ofs == 8'h03) check("config pins", cfg_pins, rows[i].rd);
    end
    wr(8'h01, 8'h80, 1'b1);
    check("power down", {7'h00, power_down}, 8'h01);
    link_detected = 1'b1;
    @(negedge clk_sys);
    check("power down link", {7'h00, power_down}, 8'h00);
    wr(8'h03, 8'h02, 1'b1);
    pclk_present = 1'b0;
    @(negedge clk_sys);
    check("osc select", {7'h00, osc_select}, 8'h01);
    pclk_present = 1'b1;
    dev = 7'h13;
    wr(8'h03, 8'h55, 1'b0);
    dev = 7'h12;
    rd(8'h03, d);
    check("ignored write", d, 8'h02);
    wr(8'h00, 8'h55, 1'b1);
    check("override addr", {1'b0, active_bus_addr}, 8'h2a);
    dev = 7'h2a;
    rd(8'h00, d);
    check("addr reg", d, 8'h55);
    wr(8'h00, 8'h00, 1'b1);
    dev = 7'h12;
    for (int c = 0; c < 16; c++) begin
      address_select_pin = c[3:0];
      @(negedge clk_sys);
      check("pin addr", {1'b0, active_bus_addr}, 8'h0c + 8'(2 * c));
    end
    address_select_pin = 4'h3;
    p0 = pulses;
    wr(8'h01, 8'h81, 1'b1);
    check("logic pulses", 8'(pulses - p0), 8'h01);
    rd(8'h01, d);
    check("logic reset keeps", d, 8'h80);
    rd(8'h03, d);
    check("config kept", d, 8'h02);
    clk_en = 1'b0;
    wr(8'h03, 8'h55, 1'b0);
    clk_en = 1'b1;
    rd(8'h03, d);
    check("frozen config", d, 8'h02);
    p0 = pulses;
    wr(8'h01, 8'h02, 1'b1);
    check("full pulses", 8'(pulses - p0), 8'h01);
    rd(8'h03, d);
    check("full reset config", d, 8'hd2);
    rd(8'h01, d);
    check("full reset reg", d, 8'h00);
    finish_test();
  end
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule // tb
